//--- hw/tbu_timer.sv
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module tbu_timer
	import tbu_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        gear_clk_en,
	input  wire logic        low_frequency_clock,
	input  wire logic        low_freq_source_select,
	input  wire logic        slow_mode,
	input  wire logic        stop_entry,
	input  wire logic [15:0] reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output var  logic [7:0]  reg_rdata,
	output var  logic        tick_interrupt_request,
	output var  logic        irq
);
	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	tbu_tap_if t ();

	tbu_lf_sync u_sync (
		.mclk                (mclk),
		.rst_n               (rst_n),
		.low_frequency_clock (low_frequency_clock),
		.t                   (t.sync)
	);

	tbu_divider u_div (
		.mclk        (mclk),
		.rst_n       (rst_n),
		.gear_clk_en (gear_clk_en),
		.t           (t.div)
	);

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic wr_ctrl;
	logic wr_status;
	logic wr_mask;

	assign wr_ctrl   = reg_wr && (reg_addr == TBU_CTRL_ADDR);
	assign wr_status = reg_wr && (reg_addr == TBU_STATUS_ADDR);
	assign wr_mask   = reg_wr && (reg_addr == TBU_MASK_ADDR);

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	logic                  tick_irq_enable;
	logic [TBU_RATE_W-1:0] tick_rate_select;
	logic                  next_tick_irq_enable;
	logic [TBU_RATE_W-1:0] next_tick_rate_select;

	always_comb begin
		next_tick_irq_enable  = tick_irq_enable;
		next_tick_rate_select = tick_rate_select;
		if (stop_entry) begin
			// Stop wins over a write in the same cycle
			next_tick_irq_enable = 1'b0;
		end else if (wr_ctrl) begin
			next_tick_irq_enable  = reg_wdata[TBU_EN_BIT];
			next_tick_rate_select = reg_wdata[TBU_RATE_LSB +: TBU_RATE_W];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_irq_enable  <= TBU_CTRL_RESET[TBU_EN_BIT];
			tick_rate_select <= TBU_CTRL_RESET[TBU_RATE_LSB +: TBU_RATE_W];
		end else begin
			tick_irq_enable  <= next_tick_irq_enable;
			tick_rate_select <= next_tick_rate_select;
		end
	end

	assign t.rate      = tick_rate_select;
	assign t.lf_select = low_freq_source_select;
	assign t.slow_mode = slow_mode;

	// ------------------------------------------------------------
	// Falling edge detect and request pulse
	// ------------------------------------------------------------
	logic tap_q;
	logic next_tap_q;
	logic tap_fall;
	logic req_event;
	logic next_request;

	// Chain is not touched here, so the first interval can be short
	assign tap_fall  = tap_q & ~t.tap;
	assign req_event = tap_fall & tick_irq_enable;

	always_comb begin
		next_tap_q   = t.tap;
		next_request = req_event;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tap_q                  <= 1'b0;
			tick_interrupt_request <= 1'b0;
		end else begin
			tap_q                  <= next_tap_q;
			tick_interrupt_request <= next_request;
		end
	end

	// ------------------------------------------------------------
	// Sticky status, mask and interrupt line
	// ------------------------------------------------------------
	logic status;
	logic mask;
	logic next_status;
	logic next_mask;
	logic next_irq;

	always_comb begin
		next_status = status;
		next_mask   = mask;
		if (wr_status && reg_wdata[TBU_EVENT_BIT]) begin
			next_status = 1'b0;
		end
		// Set wins over a clear in the same cycle
		if (req_event) begin
			next_status = 1'b1;
		end
		if (wr_mask) begin
			next_mask = reg_wdata[TBU_EVENT_BIT];
		end
		next_irq = next_status & next_mask;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status <= TBU_STATUS_RESET;
			mask   <= TBU_MASK_RESET;
			irq    <= 1'b0;
		end else begin
			status <= next_status;
			mask   <= next_mask;
			irq    <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// Read port, data valid one cycle after the strobe only
	// ------------------------------------------------------------
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				TBU_CTRL_ADDR: begin
					next_rdata = {4'h0, tick_irq_enable, tick_rate_select};
				end
				TBU_STATUS_ADDR: begin
					next_rdata = {7'h00, status};
				end
				TBU_MASK_ADDR: begin
					next_rdata = {7'h00, mask};
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_req_needs_en;
		@(posedge mclk) disable iff (!rst_n)
		tick_interrupt_request |-> $past(tick_irq_enable) && $past(tap_fall);
	endproperty
	a_req_needs_en: assert property (p_req_needs_en) else $error("request while disabled");

	property p_req_on_fall;
		@(posedge mclk) disable iff (!rst_n)
		(tap_q && !t.tap && tick_irq_enable) |=> tick_interrupt_request;
	endproperty
	a_req_on_fall: assert property (p_req_on_fall) else $error("falling edge lost");

	property p_first_req;
		@(posedge mclk) disable iff (!rst_n)
		($rose(tick_irq_enable) ##[0:300] (tap_fall && tick_irq_enable)) |=> tick_interrupt_request;
	endproperty
	a_first_req: assert property (p_first_req) else $error("first request missed");

	property p_req_pulse;
		@(posedge mclk) disable iff (!rst_n)
		tick_interrupt_request |=> !tick_interrupt_request;
	endproperty
	a_req_pulse: assert property (p_req_pulse) else $error("request wider than one cycle");

	property p_stop_clears;
		@(posedge mclk) disable iff (!rst_n)
		stop_entry |=> !tick_irq_enable && $stable(tick_rate_select);
	endproperty
	a_stop_clears: assert property (p_stop_clears) else $error("stop entry mishandled");

	property p_upper_zero;
		@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == TBU_CTRL_ADDR) |=> reg_rdata[7:4] == 4'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper control bits not zero");

	property p_ctrl_readback;
		@(posedge mclk) disable iff (!rst_n)
		(reg_rd && reg_addr == TBU_CTRL_ADDR)
			|=> reg_rdata[3:0] == {$past(tick_irq_enable), $past(tick_rate_select)};
	endproperty
	a_ctrl_readback: assert property (p_ctrl_readback) else $error("control readback wrong");

	property p_irq_level;
		@(posedge mclk) disable iff (!rst_n)
		irq == (status & mask);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt line mismatch");

	property p_status_sticky;
		@(posedge mclk) disable iff (!rst_n)
		tick_interrupt_request |-> status;
	endproperty
	a_status_sticky: assert property (p_status_sticky) else $error("event not latched");
endmodule // tbu_timer
`default_nettype wire

//--- pkg/tbu_pkg.sv
`default_nettype none
package tbu_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [15:0] TBU_CTRL_ADDR   = 16'h0039;
	localparam logic [15:0] TBU_STATUS_ADDR = 16'h003A;
	localparam logic [15:0] TBU_MASK_ADDR   = 16'h003B;
	localparam logic [7:0]  TBU_CTRL_RESET  = 8'h00;
	localparam logic        TBU_STATUS_RESET = 1'b0;
	localparam logic        TBU_MASK_RESET  = 1'b0;
	localparam int          TBU_EN_BIT      = 3;
	localparam int          TBU_RATE_LSB    = 0;
	localparam int          TBU_RATE_W      = 3;
	localparam int          TBU_EVENT_BIT   = 0;

	// ------------------------------------------------------------
	// Divider chain
	// ------------------------------------------------------------
	localparam int TBU_GEAR_W = 22;
	localparam int TBU_LF_W   = 15;
	// Tap bit n-1 gives a period of 2^n source ticks
	localparam int TBU_GEAR_TAP [0:7] = '{21, 19, 14, 12, 11, 10, 9, 7};
	localparam int TBU_LF_TAP   [0:6] = '{14, 12, 7, 5, 4, 3, 2};
	localparam logic [2:0] TBU_LF_RESERVED = 3'h7;
	localparam logic [2:0] TBU_SLOW_MAX    = 3'h1;
endpackage
`default_nettype wire

//--- pkg/tbu_tap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tbu_tap_if;
	logic       lf_tick;
	logic [2:0] rate;
	logic       lf_select;
	logic       slow_mode;
	logic       tap;

	modport sync (output lf_tick);
	modport div  (input lf_tick, input rate, input lf_select, input slow_mode, output tap);
	modport ctl  (output rate, output lf_select, output slow_mode, input tap);
endinterface
`default_nettype wire

//--- hw/tbu_lf_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tbu_lf_sync
	import tbu_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic low_frequency_clock,
	tbu_tap_if.sync   t
);
	// ------------------------------------------------------------
	// Two-stage synchroniser and rising edge detect
	// ------------------------------------------------------------
	logic sync1;
	logic sync2;
	logic sync3;
	logic next_sync1;
	logic next_sync2;
	logic next_sync3;

	always_comb begin
		next_sync1 = low_frequency_clock;
		next_sync2 = sync1;
		next_sync3 = sync2;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
		end
	end

	// Edge lands on a system clock edge, so its timing jitters
	assign t.lf_tick = sync2 & ~sync3;

	property p_lf_edge;
		@(posedge mclk) disable iff (!rst_n)
		t.lf_tick |=> !t.lf_tick;
	endproperty
	a_lf_edge: assert property (p_lf_edge) else $error("lf tick longer than one cycle");
endmodule // tbu_lf_sync
`default_nettype wire

//--- hw/tbu_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tbu_divider
	import tbu_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic gear_clk_en,
	tbu_tap_if.div    t
);
	// ------------------------------------------------------------
	// Free-running chains, never cleared by the enable bit
	// ------------------------------------------------------------
	logic [TBU_GEAR_W-1:0] gear_count;
	logic [TBU_LF_W-1:0]   lf_count;
	logic [TBU_GEAR_W-1:0] next_gear_count;
	logic [TBU_LF_W-1:0]   next_lf_count;
	logic                  use_lf;

	always_comb begin
		next_gear_count = gear_count;
		next_lf_count   = lf_count;
		if (gear_clk_en) begin
			next_gear_count = gear_count + 1'b1;
		end
		if (t.lf_tick) begin
			next_lf_count = lf_count + 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gear_count <= '0;
			lf_count   <= '0;
		end else begin
			gear_count <= next_gear_count;
			lf_count   <= next_lf_count;
		end
	end

	// ------------------------------------------------------------
	// Tap select
	// ------------------------------------------------------------
	assign use_lf = t.lf_select | t.slow_mode;

	always_comb begin
		t.tap = 1'b0;
		if (!use_lf) begin
			t.tap = gear_count[TBU_GEAR_TAP[t.rate]];
		end else if (t.rate == TBU_LF_RESERVED) begin
			t.tap = 1'b0;
		end else if (t.slow_mode && (t.rate > TBU_SLOW_MAX)) begin
			t.tap = 1'b0;
		end else begin
			t.tap = lf_count[TBU_LF_TAP[t.rate]];
		end
	end

	property p_chain_free;
		@(posedge mclk) disable iff (!rst_n)
		(rst_n && gear_clk_en) |=> gear_count == $past(gear_count) + 22'h00_0001;
	endproperty
	a_chain_free: assert property (p_chain_free) else $error("gear chain missed a tick");

	property p_gear_tap;
		@(posedge mclk) disable iff (!rst_n)
		(!use_lf && t.rate == 3'h0) |-> t.tap == gear_count[21];
	endproperty
	a_gear_tap: assert property (p_gear_tap) else $error("wrong gear tap for code 0");

	property p_slow_reserved;
		@(posedge mclk) disable iff (!rst_n)
		(t.slow_mode && t.rate > 3'h1) |-> !t.tap;
	endproperty
	a_slow_reserved: assert property (p_slow_reserved) else $error("slow tap not quiet");
endmodule // tbu_divider
`default_nettype wire

//--- sim/tbu_irq_model.sv
`timescale 1ns/1ps
`default_nettype none
module tbu_irq_model (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        tick_interrupt_request,
	output var  logic [31:0] pulse_count,
	output var  logic [31:0] last_gap,
	output var  logic        wide_seen
);
	logic [31:0] since;
	logic        req_q;

	// ------------------------------------------------------------
	// Request pulse counting and spacing
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_count <= 32'h0000_0000;
			last_gap    <= 32'h0000_0000;
			wide_seen   <= 1'b0;
			since       <= 32'h0000_0000;
			req_q       <= 1'b0;
		end else begin
			req_q <= tick_interrupt_request;
			since <= since + 32'h0000_0001;
			if (tick_interrupt_request) begin
				pulse_count <= pulse_count + 32'h0000_0001;
				last_gap    <= since;
				since       <= 32'h0000_0001;
			end
			if (tick_interrupt_request && req_q)
				wide_seen <= 1'b1;
		end
	end
endmodule // tbu_irq_model
`default_nettype wire

//--- sim/tbu_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module tbu_timer_test;
	import tbu_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        gear_clk_en = 1'b1;
	logic        lf_clk = 1'b0;
	logic        lf_sel = 1'b0;
	logic        slow_mode = 1'b0;
	logic        stop_entry = 1'b0;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        tick_req;
	logic        irq;
	logic [31:0] pulse_count;
	logic [31:0] last_gap;
	logic        wide_seen;
	logic [7:0]  rd_val;
	logic [31:0] cnt0;
	int          mismatches = 0;
	int          checks_done = 0;
	localparam logic [2:0]  code_tab [0:3] = '{3'h4, 3'h5, 3'h6, 3'h7};
	localparam logic [31:0] gap_tab  [0:3] = '{32'h0000_1000, 32'h0000_0800,
		32'h0000_0400, 32'h0000_0100};

	always #2 mclk = ~mclk;
	always #20 lf_clk = ~lf_clk;

	tbu_timer u_tbu_timer (
		.mclk                   (mclk),
		.rst_n                  (rst_n),
		.gear_clk_en            (gear_clk_en),
		.low_frequency_clock    (lf_clk),
		.low_freq_source_select (lf_sel),
		.slow_mode              (slow_mode),
		.stop_entry             (stop_entry),
		.reg_addr               (reg_addr),
		.reg_wdata              (reg_wdata),
		.reg_wr                 (reg_wr),
		.reg_rd                 (reg_rd),
		.reg_rdata              (reg_rdata),
		.tick_interrupt_request (tick_req),
		.irq                    (irq)
	);

	tbu_irq_model u_tbu_irq_model (
		.mclk                   (mclk),
		.rst_n                  (rst_n),
		.tick_interrupt_request (tick_req),
		.pulse_count            (pulse_count),
		.last_gap               (last_gap),
		.wide_seen              (wide_seen)
	);

	// ------------------------------------------------------------
	// Bus, compare and closing tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (exp !== got) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_pulses(input int k);
		cnt0 = pulse_count;
		for (int i = 0; i < 20000 && pulse_count < cnt0 + k; i++)
			@(posedge mclk);
		#1;
		chk("pulses", cnt0 + k, pulse_count);
	endtask

	task automatic first_pulse(input logic [31:0] limit);
		int n;
		n = 0;
		cnt0 = pulse_count;
		while (n < 20000 && pulse_count == cnt0) begin
			@(posedge mclk);
			n++;
		end
		chk("first interval", 32'h0000_0001, {31'h0, n <= limit + 4});
	endtask

	task automatic quiet(input string what);
		cnt0 = pulse_count;
		repeat (600) @(posedge mclk);
		chk(what, cnt0, pulse_count);
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		complete_run();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		rd(TBU_CTRL_ADDR);
		chk("ctrl reset", {24'h0, TBU_CTRL_RESET}, {24'h0, rd_val});
		rd(TBU_STATUS_ADDR);
		chk("status reset", 32'h0000_0000, {24'h0, rd_val});
		for (int r = 0; r < 4; r++) begin
			wr(TBU_CTRL_ADDR, {5'h1E, code_tab[r]});
			rd(TBU_CTRL_ADDR);
			chk("ctrl rate", {29'h0, code_tab[r]}, {24'h0, rd_val});
			wr(TBU_CTRL_ADDR, {5'h01, code_tab[r]});
			first_pulse(gap_tab[r]);
			wait_pulses(1);
			chk("gear gap", gap_tab[r], last_gap);
			wr(TBU_CTRL_ADDR, {5'h00, code_tab[r]});
		end
		quiet("disabled");
		wr(TBU_CTRL_ADDR, 8'h0F);
		@(posedge mclk);
		stop_entry <= 1'b1;
		@(posedge mclk);
		stop_entry <= 1'b0;
		rd(TBU_CTRL_ADDR);
		chk("ctrl stop", 32'h0000_0007, {24'h0, rd_val});
		quiet("after stop");
		chk("irq masked", 32'h0000_0000, {31'h0, irq});
		rd(TBU_STATUS_ADDR);
		chk("status set", 32'h0000_0001, {24'h0, rd_val});
		wr(TBU_MASK_ADDR, 8'h01);
		#1;
		chk("irq on", 32'h0000_0001, {31'h0, irq});
		wr(TBU_STATUS_ADDR, 8'h01);
		@(posedge mclk);
		#1;
		chk("irq clear", 32'h0000_0000, {31'h0, irq});
		wr(16'h0040, 8'hFF);
		rd(16'h0040);
		chk("unmapped", 32'h0000_0000, {24'h0, rd_val});
		@(posedge mclk);
		lf_sel <= 1'b1;
		wr(TBU_CTRL_ADDR, 8'h0E);
		wait_pulses(2);
		chk("lf gap", 32'h0000_0001, {31'h0, last_gap >= 78 && last_gap <= 82});
		wr(TBU_CTRL_ADDR, 8'h07);
		wr(TBU_CTRL_ADDR, 8'h0F);
		quiet("lf reserved");
		wr(TBU_CTRL_ADDR, 8'h02);
		slow_mode <= 1'b1;
		wr(TBU_CTRL_ADDR, 8'h0A);
		quiet("slow reserved");
		chk("pulse width", 32'h0000_0000, {31'h0, wide_seen});
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd(TBU_CTRL_ADDR);
		chk("ctrl re-reset", {24'h0, TBU_CTRL_RESET}, {24'h0, rd_val});
		rd(TBU_MASK_ADDR);
		chk("mask re-reset", {31'h0, TBU_MASK_RESET}, {24'h0, rd_val});
		chk("irq re-reset", 32'h0000_0000, {31'h0, irq});
		complete_run();
	end
endmodule // tbu_timer_test
`default_nettype wire
